// ### design/rss_core.sv
// apb-programmed rotate/subtract/skip execution core with its data memory
`timescale 1ns/10ps
module rss_core import rss_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// =================================================================
	// state
	logic [7:0] acc_q;
	logic [7:0] imm_q;
	logic [5:0] flags_q;
	logic skip_q;
	logic [4:0] op_q;
	logic [2:0] bitsel_q;
	logic [2:0] adr_q;
	logic [7:0] mem_q [MEM_DEPTH];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] rd_d;

	logic setup;
	logic access;
	logic wr_ok;
	logic start;
	logic exec;
	logic busy;

	rss_alu_if alu_io ();

	// =================================================================
	// apb handshake
	// setup phase decodes; access phase completes with no wait state
	assign setup = psel & ~penable;
	assign access = psel & penable & pready_q;
	// a write flagged at setup is dropped, so the error and the effect always agree
	assign wr_ok = access & pwrite & ~pslverr_q;
	assign start = wr_ok & (paddr == ADDR_CMD);

	// ready rises for exactly the access cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	// error: unmapped word, or a write while busy
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setup & (~rss_hit(paddr) | (pwrite & busy));
		end
	end

	// read mux; unmapped and reserved bits read as zero
	always_comb begin
		rd_d = 32'h0000_0000;
		if (paddr == ADDR_CMD) begin
			rd_d[CMD_OP_LSB +: 5] = op_q;
			rd_d[CMD_BIT_LSB +: 3] = bitsel_q;
			rd_d[CMD_ADR_LSB +: 3] = adr_q;
		end else if (paddr == ADDR_STAT) begin
			rd_d[5:0] = flags_q;
			rd_d[STAT_SKIP] = skip_q;
			rd_d[STAT_BUSY] = busy;
		end else if (paddr == ADDR_ACC) begin
			rd_d[7:0] = acc_q;
		end else if (paddr == ADDR_IMM) begin
			rd_d[7:0] = imm_q;
		end else if (rss_hit(paddr)) begin
			rd_d[7:0] = mem_q[rss_mem_idx(paddr)];
		end
	end

	// read data is captured in setup and held through access
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// =================================================================
	// command register: a write here launches the instruction
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			op_q <= 5'h00;
			bitsel_q <= 3'h0;
			adr_q <= 3'h0;
		end else if (start) begin
			op_q <= pwdata[CMD_OP_LSB +: 5];
			bitsel_q <= pwdata[CMD_BIT_LSB +: 3];
			adr_q <= pwdata[CMD_ADR_LSB +: 3];
		end
	end

	// immediate operand register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			imm_q <= RST_BYTE;
		end else if (wr_ok && paddr == ADDR_IMM) begin
			imm_q <= pwdata[7:0];
		end
	end

	// =================================================================
	// sequencing and arithmetic
	rss_seq u_seq (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(start),
		.two_cycle(rss_is_skip(pwdata[CMD_OP_LSB +: 5])),
		.exec(exec),
		.busy(busy)
	);

	assign alu_io.op = rss_op_e'(op_q);
	assign alu_io.acc = acc_q;
	assign alu_io.mem = mem_q[adr_q];
	assign alu_io.imm = imm_q;
	assign alu_io.flags = flags_q;
	assign alu_io.bitsel = bitsel_q;

	rss_alu u_alu (
		.io(alu_io)
	);

	// =================================================================
	// commit at the end of the execute cycle
	// accumulator: software load when idle, result on commit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= RST_BYTE;
		end else if (exec && alu_io.wr_acc) begin
			acc_q <= alu_io.result;
		end else if (wr_ok && paddr == ADDR_ACC) begin
			acc_q <= pwdata[7:0];
		end
	end

	// flags: subtracts rewrite six, rotates through carry only carry, the rest none
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= RST_FLAGS;
		end else if (exec) begin
			flags_q <= alu_io.flags_nx;
		end else if (wr_ok && paddr == ADDR_STAT) begin
			flags_q <= pwdata[5:0];
		end
	end

	// skip outcome of the last instruction; a new command clears it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_q <= 1'b0;
		end else if (exec) begin
			skip_q <= alu_io.skip;
		end else if (start) begin
			skip_q <= 1'b0;
		end
	end

	// data memory: apb writes when idle, write-back on commit
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < MEM_DEPTH; i++) begin
				mem_q[i] <= RST_BYTE;
			end
		end else if (exec && alu_io.wr_mem) begin
			mem_q[adr_q] <= alu_io.result;
		end else if (wr_ok && paddr >= ADDR_MEM) begin
			mem_q[rss_mem_idx(paddr)] <= pwdata[7:0];
		end
	end

	// =================================================================
	// checks: snapshot of operands taken at the execute edge
	logic [7:0] snap_m_q;
	logic [7:0] snap_a_q;
	logic snap_c_q;
	logic [2:0] snap_adr_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			snap_m_q <= RST_BYTE;
			snap_a_q <= RST_BYTE;
			snap_c_q <= 1'b0;
			snap_adr_q <= 3'h0;
		end else if (exec) begin
			snap_m_q <= alu_io.mem;
			snap_a_q <= acc_q;
			snap_c_q <= flags_q[FLG_C];
			snap_adr_q <= adr_q;
		end
	end

	property p_rotate_left_via_carry_to_acc;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_ROTATE_LEFT_VIA_CARRY_TO_ACC) |=>
			(acc_q == {snap_m_q[6:0], snap_c_q}) && (flags_q[FLG_C] == snap_m_q[7]) &&
			(mem_q[snap_adr_q] == snap_m_q);
	endproperty
	a_rotate_left_via_carry_to_acc: assert property (p_rotate_left_via_carry_to_acc) else $error("rotate left via carry wrong");

	property p_rr;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_ROTATE_RIGHT) |=>
			(mem_q[snap_adr_q] == {snap_m_q[0], snap_m_q[7:1]}) && $stable(flags_q);
	endproperty
	a_rr: assert property (p_rr) else $error("rotate right to memory wrong");

	property p_rra;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_ROTATE_RIGHT_TO_ACC) |=>
			(acc_q == {snap_m_q[0], snap_m_q[7:1]}) && (mem_q[snap_adr_q] == snap_m_q) &&
			(flags_q[FLG_C] == snap_c_q);
	endproperty
	a_rra: assert property (p_rra) else $error("rotate right to acc wrong");

	property p_rrc;
		@(posedge mclk) disable iff (!rst_n)
		(exec && (op_q == OP_ROTATE_RIGHT_VIA_CARRY || op_q == OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC)) |=>
			(flags_q[FLG_C] == snap_m_q[0]) &&
			((op_q == OP_ROTATE_RIGHT_VIA_CARRY) ? mem_q[snap_adr_q] : acc_q) == {snap_c_q, snap_m_q[7:1]};
	endproperty
	a_rrc: assert property (p_rrc) else $error("rotate right via carry wrong");

	property p_sub;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SUBTRACT) |=>
			(acc_q == snap_a_q - snap_m_q) && (flags_q[FLG_C] == (snap_a_q >= snap_m_q)) &&
			(flags_q[FLG_Z] == (snap_a_q == snap_m_q));
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result or carry wrong");

	property p_subtract_with_borrow_to_mem;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SUBTRACT_WITH_BORROW_TO_MEM) |=>
			(mem_q[snap_adr_q] == snap_a_q - snap_m_q - {7'h00, ~snap_c_q}) && $stable(acc_q);
	endproperty
	a_subtract_with_borrow_to_mem: assert property (p_subtract_with_borrow_to_mem) else $error("borrow subtract to memory wrong");

	property p_sdz;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_DECREMENT_SKIP_IF_NULL) |=>
			(mem_q[snap_adr_q] == snap_m_q - ONE) && (skip_q == (snap_m_q == ONE));
	endproperty
	a_sdz: assert property (p_sdz) else $error("decrement and skip wrong");

	property p_snz;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SKIP_IF_NONNULL) |=> (skip_q == (snap_m_q != RST_BYTE)) && $stable(flags_q);
	endproperty
	a_snz: assert property (p_snz) else $error("skip if nonzero wrong");

	property p_skip_time;
		@(posedge mclk) disable iff (!rst_n)
		(start && rss_is_skip(pwdata[CMD_OP_LSB +: 5])) |=> busy [*2] ##1 !busy;
	endproperty
	a_skip_time: assert property (p_skip_time) else $error("skip did not take two cycles");

	property p_plain_time;
		@(posedge mclk) disable iff (!rst_n)
		(start && !rss_is_skip(pwdata[CMD_OP_LSB +: 5])) |=> exec ##1 !busy;
	endproperty
	a_plain_time: assert property (p_plain_time) else $error("plain op not single cycle");

	property p_set;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SET_BYTE) |=> (mem_q[snap_adr_q] == ALL_ONES) && $stable(flags_q);
	endproperty
	a_set: assert property (p_set) else $error("set byte wrong");

	property p_rotate_right_via_carry_to_acc;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC) |=>
			(acc_q == {snap_c_q, snap_m_q[7:1]}) && (mem_q[snap_adr_q] == snap_m_q);
	endproperty
	a_rotate_right_via_carry_to_acc: assert property (p_rotate_right_via_carry_to_acc) else $error("rotate right via carry to acc wrong");

	property p_sbc;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SUBTRACT_WITH_BORROW) |=>
			(acc_q == snap_a_q - snap_m_q - {7'h00, ~snap_c_q}) && (mem_q[snap_adr_q] == snap_m_q);
	endproperty
	a_sbc: assert property (p_sbc) else $error("borrow subtract from memory wrong");

	property p_sbci;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SUBTRACT_WITH_BORROW_IMM) |=>
			(acc_q == snap_a_q - imm_q - {7'h00, ~snap_c_q});
	endproperty
	a_sbci: assert property (p_sbci) else $error("borrow subtract of immediate wrong");

	// only subtracts may touch the five flags above carry
	property p_keep_flags;
		@(posedge mclk) disable iff (!rst_n)
		(exec && (op_q < OP_SUBTRACT || op_q > OP_SUBTRACT_WITH_BORROW_TO_MEM)) |=> $stable(flags_q[5:1]);
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("non-subtract changed status flags");

	property p_decrement_to_acc_skip_if_null;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_DECREMENT_TO_ACC_SKIP_IF_NULL) |=>
			(acc_q == snap_m_q - ONE) && (mem_q[snap_adr_q] == snap_m_q) && (skip_q == (snap_m_q == ONE));
	endproperty
	a_decrement_to_acc_skip_if_null: assert property (p_decrement_to_acc_skip_if_null) else $error("decrement to acc and skip wrong");

	property p_siz;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_INCREMENT_SKIP_IF_NULL) |=>
			(mem_q[snap_adr_q] == snap_m_q + ONE) && (skip_q == (snap_m_q == ALL_ONES));
	endproperty
	a_siz: assert property (p_siz) else $error("increment and skip wrong");

	property p_increment_to_acc_skip_if_null;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_INCREMENT_TO_ACC_SKIP_IF_NULL) |=>
			(acc_q == snap_m_q + ONE) && (mem_q[snap_adr_q] == snap_m_q) && (skip_q == (snap_m_q == ALL_ONES));
	endproperty
	a_increment_to_acc_skip_if_null: assert property (p_increment_to_acc_skip_if_null) else $error("increment to acc and skip wrong");

	property p_setbit;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SET_BIT) |=> mem_q[snap_adr_q][bitsel_q] &&
			(((mem_q[snap_adr_q] ^ snap_m_q) & ~(ONE << bitsel_q)) == RST_BYTE) && $stable(flags_q);
	endproperty
	a_setbit: assert property (p_setbit) else $error("set bit wrong");

	property p_snzb;
		@(posedge mclk) disable iff (!rst_n)
		(exec && op_q == OP_SKIP_IF_NONNULL_BIT) |=> (skip_q == snap_m_q[bitsel_q]) && $stable(flags_q);
	endproperty
	a_snzb: assert property (p_snzb) else $error("skip if bit nonzero wrong");

endmodule

// ### design/rss_pkg.sv
// constants, types and helpers shared by the rotate/subtract/skip datapath
// =====================================================================
package rss_pkg;

	// =================================================================
	// register map (byte addresses on the apb side)
	localparam logic [11:0] ADDR_CMD = 12'h000;
	localparam logic [11:0] ADDR_STAT = 12'h004;
	localparam logic [11:0] ADDR_ACC = 12'h008;
	localparam logic [11:0] ADDR_IMM = 12'h00c;
	localparam logic [11:0] ADDR_MEM = 12'h020;
	localparam int MEM_DEPTH = 8;

	// =================================================================
	// field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BIT_LSB = 5;
	localparam int CMD_ADR_LSB = 8;
	localparam int FLG_C = 0;
	localparam int FLG_AC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_SC = 4;
	localparam int FLG_CZ = 5;
	localparam int STAT_SKIP = 6;
	localparam int STAT_BUSY = 7;

	// =================================================================
	// reset values and cycle counts
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ONE = 8'h01;
	localparam int PLAIN_CYCLES = 1;
	localparam int SKIP_CYCLES = 2;

	// =================================================================
	// operations
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_ROTATE_LEFT_VIA_CARRY_TO_ACC = 5'h01,
		OP_ROTATE_RIGHT = 5'h02,
		OP_ROTATE_RIGHT_TO_ACC = 5'h03,
		OP_ROTATE_RIGHT_VIA_CARRY = 5'h04,
		OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC = 5'h05,
		OP_SUBTRACT = 5'h06,
		OP_SUBTRACT_WITH_BORROW = 5'h07,
		OP_SUBTRACT_WITH_BORROW_IMM = 5'h08,
		OP_SUBTRACT_WITH_BORROW_TO_MEM = 5'h09,
		OP_DECREMENT_SKIP_IF_NULL = 5'h0a,
		OP_DECREMENT_TO_ACC_SKIP_IF_NULL = 5'h0b,
		OP_INCREMENT_SKIP_IF_NULL = 5'h0c,
		OP_INCREMENT_TO_ACC_SKIP_IF_NULL = 5'h0d,
		OP_SKIP_IF_NONNULL = 5'h0e,
		OP_SKIP_IF_NONNULL_BIT = 5'h0f,
		OP_SET_BYTE = 5'h10,
		OP_SET_BIT = 5'h11
	} rss_op_e;

	// skip class needs the dummy cycle
	function automatic logic rss_is_skip(input logic [4:0] op);
		return (op >= OP_DECREMENT_SKIP_IF_NULL) && (op <= OP_SKIP_IF_NONNULL_BIT);
	endfunction

	// any mapped word, data memory words included
	function automatic logic rss_hit(input logic [11:0] a);
		return (a == ADDR_CMD) || (a == ADDR_STAT) || (a == ADDR_ACC) || (a == ADDR_IMM) ||
			((a >= ADDR_MEM) && (a < ADDR_MEM + 12'h020) && (a[1:0] == 2'b00));
	endfunction

	// word index into the data memory
	function automatic logic [2:0] rss_mem_idx(input logic [11:0] a);
		return a[4:2];
	endfunction

endpackage

// ### design/rss_alu_if.sv
// operand and result bundle between the core and its arithmetic unit
`timescale 1ns/10ps
interface rss_alu_if;
	import rss_pkg::*;
	rss_op_e op;
	logic [7:0] acc;
	logic [7:0] mem;
	logic [7:0] imm;
	logic [5:0] flags;
	logic [2:0] bitsel;
	logic [7:0] result;
	logic wr_acc;
	logic wr_mem;
	logic [5:0] flags_nx;
	logic skip;

	modport core (output op, acc, mem, imm, flags, bitsel, input result, wr_acc, wr_mem, flags_nx, skip);
	modport alu (input op, acc, mem, imm, flags, bitsel, output result, wr_acc, wr_mem, flags_nx, skip);
endinterface

// ### design/rss_alu.sv
// combinational arithmetic unit: rotate, subtract, step-and-skip, set
`timescale 1ns/10ps
module rss_alu import rss_pkg::*; (
	// operand and result bundle
	rss_alu_if.alu io
);

	// 9-bit difference plus nibble borrow, packed as {c, ac, ov, r}
	function automatic logic [10:0] rss_sub(input logic [7:0] a, input logic [7:0] b, input logic bin);
		logic [8:0] d;
		logic [4:0] lo;
		d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
		lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
		return {~d[8], ~lo[4], (a[7] ^ b[7]) & (d[7] ^ a[7]), d[7:0]};
	endfunction

	logic [10:0] sv;
	logic sub_bin;
	logic [7:0] sub_src;
	logic [7:0] dec_v;
	logic [7:0] inc_v;

	// shared subtractor; plain subtract has no borrow in
	assign sub_src = (io.op == OP_SUBTRACT_WITH_BORROW_IMM) ? io.imm : io.mem;
	assign sub_bin = (io.op == OP_SUBTRACT) ? 1'b0 : ~io.flags[FLG_C];
	assign sv = rss_sub(io.acc, sub_src, sub_bin);
	assign dec_v = io.mem - ONE;
	assign inc_v = io.mem + ONE;

	// operation select; unchanged flags pass straight through
	always_comb begin
		io.result = io.mem;
		io.wr_acc = 1'b0;
		io.wr_mem = 1'b0;
		io.flags_nx = io.flags;
		io.skip = 1'b0;
		unique case (io.op)
			OP_ROTATE_LEFT_VIA_CARRY_TO_ACC: begin
				io.result = {io.mem[6:0], io.flags[FLG_C]};
				io.wr_acc = 1'b1;
				io.flags_nx[FLG_C] = io.mem[7];
			end
			OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC: begin
				io.result = {io.mem[0], io.mem[7:1]};
				io.wr_mem = (io.op == OP_ROTATE_RIGHT);
				io.wr_acc = (io.op == OP_ROTATE_RIGHT_TO_ACC);
			end
			OP_ROTATE_RIGHT_VIA_CARRY, OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC: begin
				io.result = {io.flags[FLG_C], io.mem[7:1]};
				io.wr_mem = (io.op == OP_ROTATE_RIGHT_VIA_CARRY);
				io.wr_acc = (io.op == OP_ROTATE_RIGHT_VIA_CARRY_TO_ACC);
				io.flags_nx[FLG_C] = io.mem[0];
			end
			OP_SUBTRACT, OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_IMM,
			OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
				io.result = sv[7:0];
				io.wr_mem = (io.op == OP_SUBTRACT_WITH_BORROW_TO_MEM);
				io.wr_acc = (io.op != OP_SUBTRACT_WITH_BORROW_TO_MEM);
				io.flags_nx[FLG_C] = sv[10];
				io.flags_nx[FLG_AC] = sv[9];
				io.flags_nx[FLG_OV] = sv[8];
				io.flags_nx[FLG_Z] = (sv[7:0] == RST_BYTE);
				io.flags_nx[FLG_SC] = sv[8] ^ sv[7];
				// chained zero only survives if the earlier byte was zero too
				io.flags_nx[FLG_CZ] = (sv[7:0] == RST_BYTE) &
					((io.op == OP_SUBTRACT) | io.flags[FLG_CZ]);
			end
			OP_DECREMENT_SKIP_IF_NULL, OP_DECREMENT_TO_ACC_SKIP_IF_NULL: begin
				io.result = dec_v;
				io.wr_mem = (io.op == OP_DECREMENT_SKIP_IF_NULL);
				io.wr_acc = (io.op == OP_DECREMENT_TO_ACC_SKIP_IF_NULL);
				io.skip = (dec_v == RST_BYTE);
			end
			OP_INCREMENT_SKIP_IF_NULL, OP_INCREMENT_TO_ACC_SKIP_IF_NULL: begin
				io.result = inc_v;
				io.wr_mem = (io.op == OP_INCREMENT_SKIP_IF_NULL);
				io.wr_acc = (io.op == OP_INCREMENT_TO_ACC_SKIP_IF_NULL);
				io.skip = (inc_v == RST_BYTE);
			end
			OP_SKIP_IF_NONNULL: io.skip = (io.mem != RST_BYTE);
			OP_SKIP_IF_NONNULL_BIT: io.skip = io.mem[io.bitsel];
			OP_SET_BYTE: begin
				io.result = ALL_ONES;
				io.wr_mem = 1'b1;
			end
			OP_SET_BIT: begin
				io.result = io.mem | (ONE << io.bitsel);
				io.wr_mem = 1'b1;
			end
			OP_NOP: io.result = io.mem;
			default: io.result = io.mem; // undefined opcodes act as nop
		endcase
	end

endmodule

// ### design/rss_seq.sv
// instruction cycle sequencer: one execute cycle, plus a dummy for skips
`timescale 1ns/10ps
module rss_seq import rss_pkg::*; (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// control
	input wire logic start,
	input wire logic two_cycle,
	// state
	output logic exec,
	output logic busy
);

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_EXEC = 2'b01,
		SEQ_DUMMY = 2'b11
	} rss_seq_e;

	rss_seq_e state_q;
	logic two_q;

	// remember the class so the dummy is inserted after execute
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			two_q <= 1'b0;
		end else if (start) begin
			two_q <= two_cycle;
		end
	end

	// state walk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SEQ_IDLE;
		end else begin
			unique case (state_q)
				SEQ_IDLE: if (start) state_q <= SEQ_EXEC;
				SEQ_EXEC: state_q <= two_q ? SEQ_DUMMY : SEQ_IDLE;
				SEQ_DUMMY: state_q <= SEQ_IDLE;
				default: state_q <= SEQ_IDLE;
			endcase
		end
	end

	assign exec = (state_q == SEQ_EXEC);
	assign busy = (state_q != SEQ_IDLE);

endmodule

// ### dv/test_rotate_subtract_skip_alu.sv
// self-checking bench for the rotate/subtract/skip core, with an integer reference model
`timescale 1ns/10ps
module test_rotate_subtract_skip_alu import rss_pkg::*;;
	// =================================================================
	// clock, reset and apb wires
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int mismatches = 0;
	int n_tests = 0;

	// 20 mhz core clock
	always #25 mclk = ~mclk;

	rss_core rss_core_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// =================================================================
	// verdict and comparison
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// =================================================================
	// apb master: last releases psel, otherwise the next setup follows at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit last,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
		if (last) begin
			psel <= 1'b0;
			@(posedge mclk);
		end
	endtask

	// =================================================================
	// reference state
	int acc, imm, flg, sk;
	int mem [8];

	// borrow subtract model; six flags come from the full, signed and nibble differences
	task automatic model_sub(input int op, input int m);
		int b, bi, d, sd, r, ov, z;
		b = (op == 8) ? imm : m;
		bi = (op == 6) ? 0 : ((flg & 1) ^ 1);
		d = acc - b - bi;
		r = d & 8'hff;
		sd = (acc > 127 ? acc - 256 : acc) - (b > 127 ? b - 256 : b) - bi;
		ov = (sd > 127 || sd < -128) ? 1 : 0;
		z = (r == 0) ? 1 : 0;
		flg = ((d >= 0) << FLG_C) | ((((acc & 15) - (b & 15) - bi) >= 0) << FLG_AC) | (z << FLG_Z) |
			(ov << FLG_OV) | ((ov ^ (r >> 7)) << FLG_SC) |
			(((op == 6) ? z : (z & (flg >> FLG_CZ) & 1)) << FLG_CZ);
		if (op == 9) mem[0] = r;
		else acc = r;
	endtask

	task automatic model(input int op, input int i, input int bs);
		int m, c;
		m = mem[i];
		c = flg & 1;
		sk = 0;
		case (op)
			1: begin acc = ((m << 1) & 8'hfe) | c; flg = (flg & 6'h3e) | (m >> 7); end
			2: mem[i] = (m >> 1) | ((m & 1) << 7);
			3: acc = (m >> 1) | ((m & 1) << 7);
			4: begin mem[i] = (m >> 1) | (c << 7); flg = (flg & 6'h3e) | (m & 1); end
			5: begin acc = (m >> 1) | (c << 7); flg = (flg & 6'h3e) | (m & 1); end
			6, 7, 8, 9: begin mem[0] = m; model_sub(op, m); mem[i] = (op == 9) ? mem[0] : m; end
			10: begin mem[i] = (m - 1) & 8'hff; sk = (mem[i] == 0); end
			11: begin acc = (m - 1) & 8'hff; sk = (acc == 0); end
			12: begin mem[i] = (m + 1) & 8'hff; sk = (mem[i] == 0); end
			13: begin acc = (m + 1) & 8'hff; sk = (acc == 0); end
			14: sk = (m != 0);
			15: sk = ((m >> bs) & 1);
			16: mem[i] = 8'hff;
			17: mem[i] = m | (1 << bs);
			default: ;
		endcase
	endtask

	// =================================================================
	// main sequence
	initial begin
		logic [31:0] rd;
		logic err;
		int op, i, bs;
		void'($urandom(33382));
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// reset values and an unmapped word
		apb(0, ADDR_ACC, 0, 1, rd, err);
		chk(rd, 0);
		apb(0, ADDR_STAT, 0, 1, rd, err);
		chk(rd, 0);
		apb(0, ADDR_MEM + 12'h01c, 0, 1, rd, err);
		chk(rd, 0);
		apb(0, 12'h010, 0, 1, rd, err);
		chk({rd[30:0], err}, 32'h1);
		$display("test reset and unmapped done");
		// every opcode with random operands, flags and places
		for (int rnd = 0; rnd < 12; rnd++) begin
			for (op = 0; op <= 18; op++) begin
				i = (rnd == 0) ? 0 : $urandom_range(7);
				bs = $urandom_range(7);
				acc = $urandom_range(255);
				imm = $urandom_range(255);
				flg = $urandom_range(63);
				mem[i] = (rnd < 2) ? ((op < 12) ? 1 : 8'hff) : $urandom_range(255);
				apb(1, ADDR_ACC, acc, 0, rd, err);
				apb(1, ADDR_IMM, imm, 0, rd, err);
				apb(1, ADDR_MEM + 12'(i * 4), mem[i], 0, rd, err);
				apb(1, ADDR_STAT, flg, 0, rd, err);
				apb(1, ADDR_CMD, (i << CMD_ADR_LSB) | (bs << CMD_BIT_LSB) | op, 0, rd, err);
				chk(err, 0);
				model(op, i, bs);
				apb(0, ADDR_STAT, 0, 0, rd, err);
				if (op >= 10 && op <= 15) chk(rd[STAT_BUSY], 1);
				apb(0, ADDR_STAT, 0, 1, rd, err);
				chk(rd, (sk << STAT_SKIP) | flg);
				apb(0, ADDR_ACC, 0, 1, rd, err);
				chk(rd, acc);
				apb(0, ADDR_MEM + 12'(i * 4), 0, 1, rd, err);
				chk(rd, mem[i]);
				$display("test op %h round %0d done", op, rnd);
			end
		end
		// a write whose setup falls in the execute cycle of a skip is refused
		apb(1, ADDR_ACC, 8'h33, 0, rd, err);
		apb(1, ADDR_MEM, 8'h05, 0, rd, err);
		apb(1, ADDR_CMD, OP_SKIP_IF_NONNULL, 0, rd, err);
		apb(1, ADDR_ACC, 8'h5a, 1, rd, err);
		chk(err, 1);
		apb(0, ADDR_ACC, 0, 1, rd, err);
		chk(rd, 8'h33);
		apb(0, ADDR_STAT, 0, 1, rd, err);
		chk(rd[STAT_SKIP], 1);
		apb(0, ADDR_CMD, 0, 1, rd, err);
		chk(rd, 32'(OP_SKIP_IF_NONNULL));
		$display("test busy refusal done");
		end_sim();
	end
endmodule
